/* hw/cache_sweep_and_refill_control.sv */
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "cache_sweep_defs.svh"
module cache_sweep_and_refill_control
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    // requests from the execution unit
    input wire logic memory_cycle_request_i,
    input wire logic clearer_qualifier_i,
    input wire logic load_register_qualifier_i,
    input wire logic read_register_qualifier_i,
    input wire logic refill_write_enable_i,
    input wire logic [0:35] virtual_address_reg_i,
    input wire logic [9:12] instruction_acc_field_latch_i,
    output logic memory_unit_response_o,
    output logic clearer_request_o,
    output logic clearer_idle_o,
    output logic sweep_interrupt_o,
    // cache fill, store and lookup traffic
    input wire logic fill_i,
    input wire logic [1:0] fill_way_i,
    input wire cache_sweep_pkg::page_t fill_page_i,
    input wire logic [8:0] fill_word_i,
    input wire logic store_i,
    input wire logic [1:0] store_way_i,
    input wire logic [8:0] store_word_i,
    input wire logic lookup_i,
    input wire cache_sweep_pkg::page_t lookup_page_i,
    input wire logic [8:0] lookup_word_i,
    output logic lookup_hit_o,
    output logic fetch_needed_o,
    // core writeback port
    output logic writeback_req_o,
    output cache_sweep_pkg::page_t writeback_page_o,
    output logic [8:0] writeback_word_o,
    input wire logic writeback_ack_i,
    // refill replacement lookup
    input wire logic [6:0] refill_select_i,
    output cache_sweep_pkg::refill_entry_t refill_entry_o,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import cache_sweep_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    logic valid_q [0:`CACHE_WORDS-1];
    logic written_q [0:`CACHE_WORDS-1];
    page_t tag_q [0:`CACHE_WORDS/4-1];
    refill_entry_t refill_ram_q [0:`REFILL_DEPTH-1];

    sweep_state_t state_q, state_d;
    logic [10:0] index_q;
    page_t clearer_page_q;
    logic scope_page_q;
    logic writeback_en_q;
    logic invalidate_q;
    logic [7:0] flags_q;
    logic [7:0] enables_q;
    logic response_q;
    logic clearer_req_q;
    logic wb_req_q;
    page_t wb_page_q;
    logic [8:0] wb_word_q;
    logic hit_q;
    logic fetch_q;
    refill_entry_t refill_out_q;
    logic [31:0] rdata_q;

    // ************************************************************
    // request decode
    // ************************************************************
    wire logic sweep_load;
    wire logic refill_write;
    wire logic busy;
    wire logic [8:0] tag_sel;
    wire logic word_match;
    wire logic word_act;
    wire logic needs_writeback;
    wire logic sweep_end;
    wire logic [8:0] fill_tag_sel;
    wire logic [10:0] store_idx;
    wire logic [10:0] fill_idx;

    // sweep load: clearer plus load-register qualifiers
    assign sweep_load = memory_cycle_request_i & clearer_qualifier_i
        & load_register_qualifier_i;
    assign refill_write = memory_cycle_request_i & read_register_qualifier_i
        & refill_write_enable_i;
    assign busy = (state_q != SW_IDLE);
    assign tag_sel = {index_q[10:9], index_q[8:2]};
    // whole cache ignores the stored page
    assign word_match = ~scope_page_q | (tag_q[tag_sel] == clearer_page_q);
    assign word_act = word_match & valid_q[index_q];
    assign needs_writeback = word_act & writeback_en_q & written_q[index_q];
    assign sweep_end = (index_q == `SWEEP_LAST);
    assign fill_tag_sel = {fill_way_i, fill_word_i[8:2]};
    assign store_idx = {store_way_i, store_word_i};
    assign fill_idx = {fill_way_i, fill_word_i};

    // ************************************************************
    // sweep sequencer
    // ************************************************************
    // next state of the clearer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SW_IDLE: state_d = SW_IDLE;
            SW_LOOK:
            begin
                if (needs_writeback)
                    state_d = SW_WRITEBACK;
                else
                    state_d = SW_GAP;
            end
            SW_WRITEBACK:
            begin
                if (writeback_ack_i)
                    state_d = SW_GAP;
            end
            SW_GAP:
            begin
                if (sweep_end)
                    state_d = SW_FINISH;
                else
                    state_d = SW_LOOK;
            end
            SW_FINISH: state_d = SW_IDLE;
            default: state_d = SW_IDLE;
        endcase
        // a new sweep load restarts the sweep
        if (sweep_load)
            state_d = SW_LOOK;
    end

    // state, index and clearer register
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= SW_IDLE;
            index_q <= 11'h000;
            clearer_page_q <= 9'h000;
            scope_page_q <= 1'b0;
            writeback_en_q <= 1'b0;
            invalidate_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (sweep_load)
            begin
                index_q <= 11'h000;
                clearer_page_q <= virtual_address_reg_i[27:35];
                scope_page_q <= instruction_acc_field_latch_i[10];
                writeback_en_q <= instruction_acc_field_latch_i[11];
                invalidate_q <= instruction_acc_field_latch_i[12];
            end
            else if (state_q == SW_GAP && !sweep_end)
                index_q <= index_q + 11'h001;
        end
    end

    // response pulses for both request kinds, clearer request only for a sweep load
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            response_q <= 1'b0;
            clearer_req_q <= 1'b0;
        end
        else
        begin
            response_q <= sweep_load | refill_write;
            clearer_req_q <= sweep_load;
        end
    end

    // writeback request held until acknowledged or a new sweep load
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            wb_req_q <= 1'b0;
            wb_page_q <= 9'h000;
            wb_word_q <= 9'h000;
        end
        else if (sweep_load)
            wb_req_q <= 1'b0;
        else if (state_q == SW_LOOK && needs_writeback)
        begin
            wb_req_q <= 1'b1;
            wb_page_q <= tag_q[tag_sel];
            wb_word_q <= index_q[8:0];
        end
        else if (writeback_ack_i)
            wb_req_q <= 1'b0;
    end

    // ************************************************************
    // cache valid and written bits
    // ************************************************************
    // fills and stores from traffic, clears from the clearer
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < `CACHE_WORDS; i++)
            begin
                valid_q[i] <= 1'b0;
                written_q[i] <= 1'b0;
            end
        end
        else
        begin
            if (fill_i)
            begin
                valid_q[fill_idx] <= 1'b1;
                written_q[fill_idx] <= 1'b0;
            end
            if (store_i && valid_q[store_idx])
                written_q[store_idx] <= 1'b1;
            if (state_q == SW_GAP && word_act && !sweep_load)
            begin
                if (writeback_en_q)
                    written_q[index_q] <= 1'b0;
                if (invalidate_q)
                    valid_q[index_q] <= 1'b0;
            end
        end
    end

    // quadword tags
    always_ff @(posedge clock_i)
    begin
        if (fill_i)
            tag_q[fill_tag_sel] <= fill_page_i;
    end

    // lookup: any way holding the page with the word valid
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            hit_q <= 1'b0;
            fetch_q <= 1'b0;
        end
        else
        begin
            hit_q <= 1'b0;
            fetch_q <= 1'b0;
            if (lookup_i)
            begin
                hit_q <= 1'b0;
                fetch_q <= 1'b1;
                for (int w = 0; w < 4; w++)
                begin
                    if (tag_q[{w[1:0], lookup_word_i[8:2]}] == lookup_page_i
                        && valid_q[{w[1:0], lookup_word_i}])
                    begin
                        hit_q <= 1'b1;
                        fetch_q <= 1'b0;
                    end
                end
            end
        end
    end

    // ************************************************************
    // refill replacement ram
    // ************************************************************
    // write entry bits 18-20 at location bits 27-33
    always_ff @(posedge clock_i)
    begin
        if (refill_write)
            refill_ram_q[virtual_address_reg_i[27:33]] <= virtual_address_reg_i[18:20];
    end

    // registered read of the replacement entry
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            refill_out_q <= 3'h0;
        else
            refill_out_q <= refill_ram_q[refill_select_i];
    end

    // ************************************************************
    // status flags and apb
    // ************************************************************
    wire logic apb_write;
    wire logic apb_read;
    wire logic hit_flags;
    wire logic hit_clearer;
    wire logic hit_refill;
    wire logic [7:0] flag_mask;
    wire logic done_event;
    wire logic [7:0] flag_set;
    wire logic [7:0] flag_clr;

    assign apb_write = psel & penable & pwrite;
    assign apb_read = psel & ~penable & ~pwrite;
    assign hit_flags = (paddr == `OFS_STATUS_FLAGS);
    assign hit_clearer = (paddr == `OFS_CLEARER_STATE);
    assign hit_refill = (paddr == `OFS_REFILL_READ);
    assign flag_mask = pwdata[`FLAG_MSB:`FLAG_LSB];
    assign done_event = (state_q == SW_FINISH) && !sweep_load;
    assign flag_set = ({8{apb_write & hit_flags & pwdata[`FLAG_SET_BIT]}} & flag_mask)
        | ({7'h00, done_event} << `SWEEP_DONE_POS);
    assign flag_clr = {8{apb_write & hit_flags & pwdata[`FLAG_CLEAR_BIT]}} & flag_mask;

    // sticky flags, a set beats a clear; enables by bits 20 and 21
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            flags_q <= 8'h00;
            enables_q <= 8'h00;
        end
        else
        begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
            if (apb_write && hit_flags && pwdata[`FLAG_ENABLE_BIT])
                enables_q <= enables_q | flag_mask;
            else if (apb_write && hit_flags && pwdata[`FLAG_DISABLE_BIT])
                enables_q <= enables_q & ~flag_mask;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            rdata_q <= 32'h0000_0000;
        else if (apb_read)
        begin
            rdata_q <= 32'h0000_0000;
            if (hit_flags)
                rdata_q[`FLAG_MSB:`FLAG_LSB] <= flags_q;
            else if (hit_clearer)
            begin
                rdata_q[`CLR_BUSY_BIT] <= busy;
                rdata_q[`CLR_SCOPE_BIT] <= scope_page_q;
                rdata_q[`CLR_WB_BIT] <= writeback_en_q;
                rdata_q[`CLR_INV_BIT] <= invalidate_q;
                rdata_q[`CLR_PAGE_MSB:`CLR_PAGE_LSB] <= clearer_page_q;
            end
            else if (hit_refill)
                rdata_q[2:0] <= refill_out_q;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign memory_unit_response_o = response_q;
    assign clearer_request_o = clearer_req_q;
    assign clearer_idle_o = (state_q == SW_GAP);
    assign sweep_interrupt_o = |(flags_q & enables_q);
    assign lookup_hit_o = hit_q;
    assign fetch_needed_o = fetch_q;
    assign writeback_req_o = wb_req_q;
    assign writeback_page_o = wb_page_q;
    assign writeback_word_o = wb_word_q;
    assign refill_entry_o = refill_out_q;
    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_flags | hit_clearer | hit_refill);

endmodule // cache_sweep_and_refill_control

/* hw/cache_sweep_defs.svh */
`ifndef CACHE_SWEEP_DEFS_SVH
`define CACHE_SWEEP_DEFS_SVH

// apb register offsets
`define OFS_STATUS_FLAGS 12'h000
`define OFS_CLEARER_STATE 12'h004
`define OFS_REFILL_READ 12'h008

// status flag word, lsb index = 35 - word bit
`define FLAG_ENABLE_BIT 15
`define FLAG_DISABLE_BIT 14
`define FLAG_CLEAR_BIT 13
`define FLAG_SET_BIT 12
`define FLAG_LSB 4
`define FLAG_MSB 11
`define SWEEP_DONE_POS 0

// clearer state word fields
`define CLR_BUSY_BIT 0
`define CLR_SCOPE_BIT 1
`define CLR_WB_BIT 2
`define CLR_INV_BIT 3
`define CLR_PAGE_LSB 8
`define CLR_PAGE_MSB 16

// special-constant codes
`define CODE_LOAD_CLEARER 9'o601
`define CODE_WRITE_REFILL 9'o602

// cache geometry
`define CACHE_WORDS 2048
`define PAGE_WORDS 512
`define REFILL_DEPTH 128
`define SWEEP_LAST 11'h7ff

`endif

/* hw/cache_sweep_pkg.sv */
package cache_sweep_pkg;

    typedef enum logic [2:0] {
        SW_IDLE,
        SW_LOOK,
        SW_WRITEBACK,
        SW_GAP,
        SW_FINISH
    } sweep_state_t;

    typedef logic [8:0] page_t;
    typedef logic [2:0] refill_entry_t;

endpackage

/* verification/cache_sweep_assertions.sv */
`timescale 1ns/10ps
module cache_sweep_checker
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic memory_cycle_request_i,
    input wire logic clearer_qualifier_i,
    input wire logic load_register_qualifier_i,
    input wire logic read_register_qualifier_i,
    input wire logic refill_write_enable_i,
    input wire logic memory_unit_response_o,
    input wire logic clearer_request_o,
    input wire logic clearer_idle_o,
    input wire logic lookup_i,
    input wire logic lookup_hit_o,
    input wire logic fetch_needed_o,
    input wire logic writeback_req_o,
    input wire cache_sweep_pkg::page_t writeback_page_o,
    input wire logic [8:0] writeback_word_o,
    input wire logic writeback_ack_i
);
    import cache_sweep_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // request decode as seen at the inputs
    wire sweep_ld = memory_cycle_request_i && clearer_qualifier_i && load_register_qualifier_i;
    wire refill_ld = memory_cycle_request_i && read_register_qualifier_i && refill_write_enable_i;
    wire calm = !memory_cycle_request_i;
    load_answer_a: assert property (sweep_ld |=> memory_unit_response_o && clearer_request_o)
        else $error("sweep load not answered");
    refill_answer_a: assert property (refill_ld && !sweep_ld |=> memory_unit_response_o
        && !clearer_request_o) else $error("refill write answer wrong");
    answer_cause_a: assert property (memory_unit_response_o |-> $past(sweep_ld || refill_ld))
        else $error("response without request");
    clearer_cause_a: assert property (clearer_request_o |-> $past(sweep_ld))
        else $error("clearer request without sweep load");
    idle_gap_a: assert property (clearer_idle_o |=> !clearer_idle_o)
        else $error("idle gap longer than one cycle");
    wb_hold_a: assert property (writeback_req_o && !writeback_ack_i && calm |=> writeback_req_o
        && $stable(writeback_page_o) && $stable(writeback_word_o)) else $error("writeback dropped");
    wb_done_a: assert property (writeback_req_o && writeback_ack_i && calm |=> !writeback_req_o
        && clearer_idle_o) else $error("no idle gap after writeback");
    lookup_result_a: assert property (lookup_i |=> lookup_hit_o != fetch_needed_o)
        else $error("lookup result missing");
endmodule // cache_sweep_checker

bind cache_sweep_and_refill_control cache_sweep_checker checker_u (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .memory_cycle_request_i(memory_cycle_request_i),
    .clearer_qualifier_i(clearer_qualifier_i), .load_register_qualifier_i(load_register_qualifier_i),
    .read_register_qualifier_i(read_register_qualifier_i),
    .refill_write_enable_i(refill_write_enable_i), .memory_unit_response_o(memory_unit_response_o),
    .clearer_request_o(clearer_request_o), .clearer_idle_o(clearer_idle_o), .lookup_i(lookup_i),
    .lookup_hit_o(lookup_hit_o), .fetch_needed_o(fetch_needed_o), .writeback_req_o(writeback_req_o),
    .writeback_page_o(writeback_page_o), .writeback_word_o(writeback_word_o),
    .writeback_ack_i(writeback_ack_i));

/* verification/exec_core_model.sv */
`timescale 1ns/10ps
module exec_core_model
(
    input wire logic clock_i,
    output logic request_o,
    output logic clr_q_o,
    output logic load_q_o,
    output logic read_q_o,
    output logic refill_en_o,
    output logic [0:35] va_o,
    output logic [9:12] acc_o,
    input wire logic wb_req_i,
    output logic wb_ack_o
);
    int ack_wait = 0;
    int wb_count = 0;
    int wait_n = 0;
    logic may_io = 1'b1;
    // quiet request lines at time zero
    initial
    begin
        {request_o, clr_q_o, load_q_o, read_q_o, refill_en_o, wb_ack_o} = '0;
        va_o = '0;
        acc_o = '0;
    end
    // one request pulse, trapped instead when not privileged
    task issue(input logic sweep, input logic [2:0] acc, input logic [0:35] va);
        @(posedge clock_i);
        if (may_io)
        begin
            request_o <= 1'b1;
            clr_q_o <= sweep;
            load_q_o <= sweep;
            read_q_o <= !sweep;
            refill_en_o <= !sweep;
            acc_o <= {1'b0, acc};
            va_o <= va;
            @(posedge clock_i);
            {request_o, clr_q_o, load_q_o, read_q_o, refill_en_o} <= '0;
            va_o <= ~va;
        end
    endtask
    // identity word: version in bits 9-17, serial in bits 24-35, rest zero
    function automatic logic [0:35] identity_word(input logic [8:0] version,
        input logic [11:0] serial);
        identity_word = {9'h000, version, 6'h00, serial};
    endfunction
    // core accepts writebacks after a settable delay
    always @(posedge clock_i)
    begin
        if (wb_req_i && !wb_ack_o && wait_n >= ack_wait)
        begin
            wb_ack_o <= 1'b1;
            wb_count <= wb_count + 1;
            wait_n <= 0;
        end
        else
        begin
            wb_ack_o <= 1'b0;
            wait_n <= wb_req_i ? wait_n + 1 : 0;
        end
    end
endmodule // exec_core_model

/* verification/tb_cache_sweep_and_refill_control.sv */
`timescale 1ns/10ps
`include "cache_sweep_defs.svh"
module tb_cache_sweep_and_refill_control;
    import cache_sweep_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req, clr_q, load_q, read_q, refill_en, wb_ack, resp, clr_req, idle, irq, hit, fetch;
    logic wb_req, pready, pslverr, err;
    logic [0:35] va;
    logic [9:12] acc;
    page_t wb_page;
    page_t pg = '0;
    logic [8:0] wb_word;
    logic [8:0] wd = '0;
    logic [1:0] way = '0;
    logic fill = 1'b0, store = 1'b0, lookup = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [6:0] rsel = '0;
    refill_entry_t rentry;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [0:35] idw;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    exec_core_model model_u (.clock_i(clock_i), .request_o(req), .clr_q_o(clr_q),
        .load_q_o(load_q), .read_q_o(read_q), .refill_en_o(refill_en), .va_o(va), .acc_o(acc),
        .wb_req_i(wb_req), .wb_ack_o(wb_ack));
    cache_sweep_and_refill_control dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .memory_cycle_request_i(req), .clearer_qualifier_i(clr_q), .load_register_qualifier_i(load_q),
        .read_register_qualifier_i(read_q), .refill_write_enable_i(refill_en),
        .virtual_address_reg_i(va), .instruction_acc_field_latch_i(acc),
        .memory_unit_response_o(resp), .clearer_request_o(clr_req), .clearer_idle_o(idle),
        .sweep_interrupt_o(irq), .fill_i(fill), .fill_way_i(way), .fill_page_i(pg),
        .fill_word_i(wd), .store_i(store), .store_way_i(way), .store_word_i(wd),
        .lookup_i(lookup), .lookup_page_i(pg), .lookup_word_i(wd), .lookup_hit_o(hit),
        .fetch_needed_o(fetch), .writeback_req_o(wb_req), .writeback_page_o(wb_page),
        .writeback_word_o(wb_word), .writeback_ack_i(wb_ack), .refill_select_i(rsel),
        .refill_entry_o(rentry), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial forever #20 clock_i = ~clock_i;

    // hang guard
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer, read data and error taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle cache traffic pulse: 0 fill, 1 store, 2 lookup
    task op(input int kind, input logic [1:0] w, input page_t p, input logic [8:0] n);
        @(posedge clock_i);
        fill <= kind == 0;
        store <= kind == 1;
        lookup <= kind == 2;
        way <= w;
        pg <= p;
        wd <= n;
        @(posedge clock_i);
        {fill, store, lookup} <= '0;
        #1;
    endtask

    task wait_done;
        while (irq !== 1'b1) @(posedge clock_i);
        apb(0, `OFS_STATUS_FLAGS, 0);
        chk("done flag", rd & 32'hff0, 32'h10);
        apb(1, `OFS_STATUS_FLAGS, 32'h2010);
        #1 chk("irq cleared", irq, 0);
    endtask

    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        #1 chk("idle outputs", {resp, clr_req, idle, irq, wb_req}, 0);
        apb(1, `OFS_STATUS_FLAGS, 32'h8010);
        op(0, 0, 5, 0);
        op(0, 0, 5, 1);
        op(1, 0, 5, 1);
        op(0, 1, 7, 8);
        op(1, 1, 7, 8);
        model_u.ack_wait = 6;
        // page sweep with writeback, no invalidate
        model_u.issue(1, 3'b110, {27'h0, 9'd5});
        apb(0, `OFS_CLEARER_STATE, 0);
        chk("clearer state", rd, 32'h507);
        while (wb_req !== 1'b1) @(posedge clock_i);
        chk("wb address", {wb_page, wb_word}, {9'd5, 9'd1});
        wait_done();
        chk("page wb count", model_u.wb_count, 1);
        op(2, 0, 5, 1);
        chk("kept valid", {hit, fetch}, 2'b10);
        // abandoned page sweep, then whole invalidate without writeback
        model_u.issue(1, 3'b111, {27'h0, 9'd3});
        repeat (100) @(posedge clock_i);
        model_u.issue(1, 3'b001, {27'h0, 9'h1a5});
        apb(0, `OFS_CLEARER_STATE, 0);
        chk("restart state", rd, 32'h1a509);
        wait_done();
        chk("whole wb count", model_u.wb_count, 1);
        op(2, 0, 5, 1);
        chk("invalid page5", {hit, fetch}, 2'b01);
        op(2, 1, 7, 8);
        chk("invalid page7", {hit, fetch}, 2'b01);
        // whole unload: write back and invalidate, stores only while idle
        op(0, 2, 9'h009, 9'h004);
        op(1, 2, 9'h009, 9'h004);
        model_u.issue(1, 3'b011, {27'h0, 9'h000});
        while (wb_req !== 1'b1) @(posedge clock_i);
        chk("whole wb address", {wb_page, wb_word}, {9'h009, 9'h004});
        wait_done();
        chk("unload wb count", model_u.wb_count, 2);
        op(2, 2, 9'h009, 9'h004);
        chk("unloaded", {hit, fetch}, 2'b01);
        // refill writes, the second one trapped
        model_u.issue(0, 0, {18'h0, 3'd5, 6'h0, 7'd9, 2'b11});
        model_u.may_io = 1'b0;
        model_u.issue(0, 0, {18'h0, 3'd2, 6'h0, 7'd9, 2'b00});
        model_u.may_io = 1'b1;
        rsel <= 7'd9;
        repeat (2) @(posedge clock_i);
        #1 chk("refill entry", rentry, 5);
        apb(0, `OFS_REFILL_READ, 0);
        chk("refill read", rd, 5);
        apb(0, 12'h00c, 0);
        chk("unmapped error", err, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
        // identity word layout from the execution side
        idw = model_u.identity_word(9'h1a3, 12'h5c7);
        chk("id version", idw[9:17], 9'h1a3);
        chk("id serial", idw[24:35], 12'h5c7);
        chk("id spare", {idw[0:8], idw[18:23]}, 15'h0);
        end_of_test();
    end
endmodule // tb_cache_sweep_and_refill_control
